/* include/agu_consts.svh */
`ifndef AGU_CONSTS_SVH
`define AGU_CONSTS_SVH

// Peripheral register window and its sub-regions (chosen map)
`define PERIPH_LO_ADDR 16'hf000
`define PERIPH_HI_ADDR 16'hf7ff
`define PERIPH8_LO_ADDR 16'hf000
`define PERIPH8_HI_ADDR 16'hf3ff
`define SLOW_LO_ADDR 16'hf000
`define SLOW_HI_ADDR 16'hf1ff

// Address forming constants
`define ZERO_TOP 8'h00
`define SHORT_ABS_FILL 16'hffff
`define VECTOR_PAGE 24'h000000

// Pointer steps for byte, word and longword
`define STEP_BYTE 32'h00000001
`define STEP_WORD 32'h00000002
`define STEP_LONG 32'h00000004

// Bus address steps between pieces
`define PIECE_STEP_BYTE 16'h0001
`define PIECE_STEP_WORD 16'h0002

// Opcode field positions
`define BIT_NUM_LSB 4
`define TRAP_VEC_LSB 4

`endif

/* include/agu_pkg.sv */
package agu_pkg;
	// Addressing modes
	typedef enum logic [3:0] {
		MODE_DIRECT = 4'h0, MODE_INDIRECT = 4'h1, MODE_DISP = 4'h2, MODE_POSTINC = 4'h3,
		MODE_PREDEC = 4'h4, MODE_ABS = 4'h5, MODE_IMM = 4'h6, MODE_PCREL = 4'h7, MODE_MEMIND = 4'h8
	} addr_mode_t;
	// Access sizes
	typedef enum logic [1:0] {SIZE_BYTE = 2'h0, SIZE_WORD = 2'h1, SIZE_LONG = 2'h2} acc_size_t;
	// Length of the extension field
	typedef enum logic [1:0] {EXT_8 = 2'h0, EXT_16 = 2'h1, EXT_24 = 2'h2, EXT_32 = 2'h3} ext_len_t;
	// Instruction classes
	typedef enum logic [1:0] {CLASS_ALU = 2'h0, CLASS_XFER = 2'h1, CLASS_BIT = 2'h2, CLASS_BRANCH = 2'h3} instr_class_t;
	// Top-level core states, one-hot
	typedef enum logic [3:0] {
		CPU_RESET = 4'h1, CPU_EXEC = 4'h2, CPU_HALT = 4'h4, CPU_EXCEPT = 4'h8
	} cpu_state_t;
	// Bus cycle states, one-hot
	typedef enum logic [3:0] {BS_IDLE = 4'h1, BS_T1 = 4'h2, BS_T2 = 4'h4, BS_T3 = 4'h8} bus_state_t;
	// Program halt sub-modes
	typedef enum logic [1:0] {HALT_SLEEP = 2'h0, HALT_STANDBY = 2'h1, HALT_SUBSLEEP = 2'h2} halt_kind_t;
endpackage

/* rtl/cpu_address_generation_unit.sv */
`timescale 1ns/10ps
`include "agu_consts.svh"
// What this block does
// - Drop top eight address bits, present 16
// - Address register 3-bit, data 3/4-bit field
// - 24-bit extension becomes 32 with zero top
// - Direct mode selects byte, word or long
// - Indirect address is pointer low 24 bits
// - Displacement 16 sign-extended or 24 added
// - Post-increment: access first, then add step
// - Pre-decrement: subtract step, then access result
// - Short absolute forces upper bits to one
// - 16-bit absolute sign-extends; 24-bit reaches all
// - Immediate operand of 8, 16, 32 bits
// - Extract bit number and trap vector
// - Relative branch implicit_add_op sign-extended displacement
// - Vector indirect reads long, drops first byte
// - Modes restricted by instruction class
// - Bus cycle lasts two or three states
// - Memory access: two states, 16-bit path
// - 16-bit peripherals word only; 8-bit split
// - Two-state peripheral timing equals memory timing
// - Exactly one of four core states
// - Execution holds active; halt has three modes
module cpu_address_generation_unit import agu_pkg::*; #(
	parameter logic [15:0] PERIPH_LO = `PERIPH_LO_ADDR,
	parameter logic [15:0] PERIPH_HI = `PERIPH_HI_ADDR,
	parameter logic [15:0] PERIPH8_LO = `PERIPH8_LO_ADDR,
	parameter logic [15:0] PERIPH8_HI = `PERIPH8_HI_ADDR,
	parameter logic [15:0] SLOW_LO = `SLOW_LO_ADDR,
	parameter logic [15:0] SLOW_HI = `SLOW_HI_ADDR
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic req_valid,
	input wire addr_mode_t req_mode,
	input wire instr_class_t req_class,
	input wire acc_size_t req_size,
	input wire ext_len_t req_ext_len,
	input wire logic [3:0] req_reg,
	input wire logic [31:0] req_ext,
	input wire logic [23:0] req_pc,
	input wire logic [15:0] req_opcode,
	input wire logic req_write,
	input wire logic [31:0] req_wdata,
	input wire logic reg_wr_en,
	input wire logic [2:0] reg_wr_idx,
	input wire logic [31:0] reg_wr_data,
	input wire logic [15:0] bus_rd_data,
	input wire logic halt_req,
	input wire halt_kind_t halt_kind,
	input wire logic wake_req,
	input wire logic exc_req,
	input wire logic exc_done,
	output logic busy,
	output logic done,
	output logic mode_error,
	output logic access_error,
	output logic [31:0] operand,
	output logic [15:0] ea,
	output logic [23:0] jump_target,
	output logic [2:0] bit_number,
	output logic [1:0] trap_vector,
	output logic bus_cyc,
	output logic [15:0] bus_addr,
	output logic bus_write,
	output logic bus_byte,
	output logic bus_three_state,
	output logic [15:0] bus_wr_data,
	output cpu_state_t cpu_state,
	output logic active_mode,
	output halt_kind_t halt_mode
);

	// Sign-extend a 16-bit value
	function automatic logic [31:0] sext16(input logic [15:0] v);
		return {{16{v[15]}}, v};
	endfunction

	// Inclusive address window test
	function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
		return (a >= lo) && (a <= hi);
	endfunction

	// Step for pointer update by access size
	function automatic logic [31:0] size_step(input acc_size_t s);
		case (s)
			SIZE_BYTE: return `STEP_BYTE;
			SIZE_WORD: return `STEP_WORD;
			default: return `STEP_LONG;
		endcase
	endfunction

	// Operand slice of a long register: 4-bit field picks the half
	function automatic logic [31:0] direct_operand(input logic [31:0] r, input logic [3:0] f, input acc_size_t s);
		case (s)
			SIZE_BYTE: return f[3] ? {24'h000000, r[7:0]} : {24'h000000, r[15:8]};
			SIZE_WORD: return f[3] ? {16'h0000, r[31:16]} : {16'h0000, r[15:0]};
			default: return r;
		endcase
	endfunction

	// Which modes each instruction class may use
	function automatic logic mode_legal(input instr_class_t c, input addr_mode_t m, input ext_len_t e);
		case (c)
			CLASS_ALU: return (m == MODE_DIRECT) || (m == MODE_IMM);
			CLASS_XFER: return (m != MODE_PCREL) && (m != MODE_MEMIND);
			CLASS_BIT: return (m == MODE_DIRECT) || (m == MODE_INDIRECT) || ((m == MODE_ABS) && (e == EXT_8));
			default: return (m == MODE_PCREL) || (m == MODE_MEMIND) || (m == MODE_INDIRECT) || (m == MODE_ABS);
		endcase
	endfunction

	logic rst_meta; // First reset synchroniser stage
	logic rst_local_n; // Released reset used by the whole block
	logic [31:0] regs [0:7]; // General registers, long view
	logic [31:0] ptr; // Selected pointer register
	logic [15:0] ptr_lo; // Low half, used by checks
	logic [31:0] step; // Post/pre step
	logic [31:0] disp32; // Widened displacement
	logic [31:0] next_ptr; // Pointer after update
	logic [31:0] calc_ea32; // Effective address before truncation
	logic [31:0] calc_operand; // Operand for register and immediate modes
	logic [23:0] calc_target; // Relative branch target
	logic calc_bus; // Mode needs a memory access
	logic ptr_update; // Mode writes the pointer back
	acc_size_t eff_size; // Size after forcing long for vector reads
	logic calc_p8; // Target on 8-bit peripheral path
	logic calc_p16; // Target on 16-bit peripheral path
	logic size_bad; // Byte access to a word-only register
	logic legal; // Mode allowed for class
	logic take; // Request accepted this edge
	logic accept_ok; // Accepted and allowed to act
	logic start_bus; // Accepted and starting a bus access
	logic [2:0] calc_pieces; // Bus cycles needed
	logic calc_byte; // Pieces are bytes
	logic [31:0] wr_aligned; // Write data top-aligned
	bus_state_t bus_st; // Bus cycle state
	logic [2:0] pieces_left; // Bus cycles still to run
	logic memind_op; // Current access is a vector read
	logic [31:0] rd_acc; // Read data gathered so far
	logic [31:0] next_acc; // Gathered data with this piece
	logic [31:0] wr_shift; // Remaining write data, top-aligned
	logic [31:0] next_shift; // Write data after this piece
	logic [15:0] next_addr; // Address of the following piece
	logic last_state; // Final state of the current bus cycle

	// Reset release through two flops; the raw pin only clears them
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta <= 1'b0;
			rst_local_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_local_n <= rst_meta;
		end
	end

	// Address and operand forming for the incoming request
	always_comb begin
		ptr = regs[req_reg[2:0]];
		ptr_lo = ptr[15:0];
		step = size_step(req_size);
		disp32 = (req_ext_len == EXT_16) ? sext16(req_ext[15:0]) : {`ZERO_TOP, req_ext[23:0]};
		next_ptr = ptr;
		calc_ea32 = 32'h00000000;
		calc_operand = 32'h00000000;
		calc_target = 24'h000000;
		calc_bus = 1'b0;
		ptr_update = 1'b0;
		case (req_mode)
			MODE_DIRECT: calc_operand = direct_operand(ptr, req_reg, req_size);
			MODE_INDIRECT: begin
				calc_ea32 = {`ZERO_TOP, ptr[23:0]};
				calc_bus = 1'b1;
			end
			MODE_DISP: begin
				calc_ea32 = ptr + disp32;
				calc_bus = 1'b1;
			end
			MODE_POSTINC: begin
				// Access uses the old value; the sum goes back to the full register
				calc_ea32 = {`ZERO_TOP, ptr[23:0]};
				next_ptr = ptr + step;
				ptr_update = 1'b1;
				calc_bus = 1'b1;
			end
			MODE_PREDEC: begin
				next_ptr = ptr - step;
				calc_ea32 = {`ZERO_TOP, next_ptr[23:0]};
				ptr_update = 1'b1;
				calc_bus = 1'b1;
			end
			MODE_ABS: begin
				calc_bus = 1'b1;
				if (req_ext_len == EXT_8) begin
					calc_ea32 = {`ZERO_TOP, `SHORT_ABS_FILL, req_ext[7:0]};
				end else if (req_ext_len == EXT_16) begin
					calc_ea32 = {`ZERO_TOP, {8{req_ext[15]}}, req_ext[15:0]};
				end else begin
					calc_ea32 = {`ZERO_TOP, req_ext[23:0]};
				end
			end
			MODE_IMM: begin
				// Immediate values are zero-extended to the operand port
				if (req_ext_len == EXT_8) begin
					calc_operand = {24'h000000, req_ext[7:0]};
				end else if (req_ext_len == EXT_16) begin
					calc_operand = {16'h0000, req_ext[15:0]};
				end else begin
					calc_operand = req_ext;
				end
			end
			MODE_PCREL: begin
				// Base is the next instruction's address
				if (req_ext_len == EXT_8) begin
					calc_target = req_pc + {{16{req_ext[7]}}, req_ext[7:0]};
				end else begin
					calc_target = req_pc + {{8{req_ext[15]}}, req_ext[15:0]};
				end
			end
			MODE_MEMIND: begin
				calc_ea32 = {`VECTOR_PAGE, req_ext[7:0]};
				calc_bus = 1'b1;
			end
			default: calc_bus = 1'b0;
		endcase
	end

	// Splitting into pieces by target path width
	always_comb begin
		eff_size = (req_mode == MODE_MEMIND) ? SIZE_LONG : req_size;
		calc_p8 = in_range(calc_ea32[15:0], PERIPH8_LO, PERIPH8_HI);
		calc_p16 = in_range(calc_ea32[15:0], PERIPH_LO, PERIPH_HI) && !calc_p8;
		size_bad = calc_bus && calc_p16 && (eff_size == SIZE_BYTE);
		calc_byte = (eff_size == SIZE_BYTE) || calc_p8;
		case (eff_size)
			SIZE_BYTE: calc_pieces = 3'd1;
			SIZE_WORD: calc_pieces = calc_p8 ? 3'd2 : 3'd1;
			default: calc_pieces = calc_p8 ? 3'd4 : 3'd2;
		endcase
		case (eff_size)
			SIZE_BYTE: wr_aligned = {req_wdata[7:0], 24'h000000};
			SIZE_WORD: wr_aligned = {req_wdata[15:0], 16'h0000};
			default: wr_aligned = req_wdata;
		endcase
		legal = mode_legal(req_class, req_mode, req_ext_len);
		take = req_valid && !busy && (cpu_state == CPU_EXEC);
		accept_ok = take && legal && !size_bad;
		start_bus = accept_ok && calc_bus;
	end

	// Piece bookkeeping for the running bus cycle
	always_comb begin
		last_state = ((bus_st == BS_T2) && !bus_three_state) || (bus_st == BS_T3);
		next_acc = bus_byte ? {rd_acc[23:0], bus_rd_data[7:0]} : {rd_acc[15:0], bus_rd_data};
		next_shift = bus_byte ? {wr_shift[23:0], 8'h00} : {wr_shift[15:0], 16'h0000};
		next_addr = bus_addr + (bus_byte ? `PIECE_STEP_BYTE : `PIECE_STEP_WORD);
	end

	// Register file; a pointer update beats a same-index external write
	always_ff @(posedge ref_clk or negedge rst_local_n) begin
		if (!rst_local_n) begin
			for (int i = 0; i < 8; i++) begin
				regs[i] <= 32'h00000000;
			end
		end else begin
			if (reg_wr_en) begin
				regs[reg_wr_idx] <= reg_wr_data;
			end
			if (accept_ok && ptr_update) begin
				regs[req_reg[2:0]] <= next_ptr;
			end
		end
	end

	// Bus cycle sequencer: T1, T2, and T3 only for slow registers
	always_ff @(posedge ref_clk or negedge rst_local_n) begin
		if (!rst_local_n) begin
			bus_st <= BS_IDLE;
			busy <= 1'b0;
			bus_cyc <= 1'b0;
			bus_addr <= 16'h0000;
			bus_write <= 1'b0;
			bus_byte <= 1'b0;
			bus_three_state <= 1'b0;
			bus_wr_data <= 16'h0000;
			pieces_left <= 3'd0;
			memind_op <= 1'b0;
			rd_acc <= 32'h00000000;
			wr_shift <= 32'h00000000;
		end else begin
			case (bus_st)
				BS_IDLE: begin
					if (start_bus) begin
						bus_st <= BS_T1;
						busy <= 1'b1;
						bus_cyc <= 1'b1;
						bus_addr <= calc_ea32[15:0];
						bus_byte <= calc_byte;
						bus_three_state <= in_range(calc_ea32[15:0], SLOW_LO, SLOW_HI);
						bus_write <= req_write && (req_mode != MODE_MEMIND);
						bus_wr_data <= calc_byte ? {8'h00, wr_aligned[31:24]} : wr_aligned[31:16];
						wr_shift <= wr_aligned;
						pieces_left <= calc_pieces;
						memind_op <= (req_mode == MODE_MEMIND);
						rd_acc <= 32'h00000000;
					end
				end
				BS_T1: bus_st <= BS_T2;
				BS_T2: begin
					if (bus_three_state) begin
						bus_st <= BS_T3;
					end
				end
				default: bus_st <= bus_st;
			endcase
			if (last_state) begin
				rd_acc <= next_acc;
				if (pieces_left == 3'd1) begin
					bus_st <= BS_IDLE;
					busy <= 1'b0;
					bus_cyc <= 1'b0;
				end else begin
					// Next piece of a split access starts at once
					bus_st <= BS_T1;
					pieces_left <= pieces_left - 3'd1;
					bus_addr <= next_addr;
					bus_three_state <= in_range(next_addr, SLOW_LO, SLOW_HI);
					wr_shift <= next_shift;
					bus_wr_data <= bus_byte ? {8'h00, next_shift[31:24]} : next_shift[31:16];
				end
			end
		end
	end

	// Results and one-cycle status pulses
	always_ff @(posedge ref_clk or negedge rst_local_n) begin
		if (!rst_local_n) begin
			done <= 1'b0;
			mode_error <= 1'b0;
			access_error <= 1'b0;
			operand <= 32'h00000000;
			ea <= 16'h0000;
			jump_target <= 24'h000000;
			bit_number <= 3'd0;
			trap_vector <= 2'd0;
		end else begin
			done <= 1'b0;
			mode_error <= 1'b0;
			access_error <= 1'b0;
			if (take) begin
				bit_number <= req_opcode[`BIT_NUM_LSB +: 3];
				trap_vector <= req_opcode[`TRAP_VEC_LSB +: 2];
				ea <= calc_ea32[15:0];
				if (!legal) begin
					mode_error <= 1'b1;
				end else if (size_bad) begin
					access_error <= 1'b1;
				end else if (!calc_bus) begin
					done <= 1'b1;
					operand <= calc_operand;
					if (req_mode == MODE_PCREL) begin
						jump_target <= calc_target;
					end
				end
			end
			if (last_state && (pieces_left == 3'd1)) begin
				done <= 1'b1;
				if (memind_op) begin
					jump_target <= next_acc[23:0];
				end else begin
					operand <= next_acc;
				end
			end
		end
	end

	// Top-level core state; halt only entered between accesses
	always_ff @(posedge ref_clk or negedge rst_local_n) begin
		if (!rst_local_n) begin
			cpu_state <= CPU_RESET;
			active_mode <= 1'b0;
			halt_mode <= HALT_SLEEP;
		end else begin
			case (cpu_state)
				CPU_RESET: cpu_state <= CPU_EXCEPT;
				CPU_EXEC: begin
					if (exc_req) begin
						cpu_state <= CPU_EXCEPT;
					end else if (halt_req && !busy && !req_valid) begin
						cpu_state <= CPU_HALT;
						halt_mode <= halt_kind;
					end
				end
				CPU_HALT: begin
					if (exc_req) begin
						cpu_state <= CPU_EXCEPT;
					end else if (wake_req) begin
						cpu_state <= CPU_EXEC;
					end
				end
				CPU_EXCEPT: begin
					if (exc_done) begin
						cpu_state <= CPU_EXEC;
					end
				end
				default: cpu_state <= CPU_RESET;
			endcase
			active_mode <= (cpu_state == CPU_EXCEPT && exc_done) || (cpu_state == CPU_HALT && !exc_req && wake_req)
				|| (cpu_state == CPU_EXEC && !exc_req && !(halt_req && !busy && !req_valid));
		end
	end

	property p_t1_to_t2;
		@(posedge ref_clk) disable iff (!rst_local_n) (bus_st == BS_T1) |=> (bus_st == BS_T2);
	endproperty
	a_t1_to_t2: assert property (p_t1_to_t2) else $error("bus state after T1 is not T2");

	property p_fast_no_t3;
		@(posedge ref_clk) disable iff (!rst_local_n) (bus_st == BS_T2 && !bus_three_state) |=> (bus_st != BS_T3);
	endproperty
	a_fast_no_t3: assert property (p_fast_no_t3) else $error("two-state cycle grew a third state");

	property p_slow_region;
		@(posedge ref_clk) disable iff (!rst_local_n) bus_cyc |-> (bus_three_state == in_range(bus_addr, SLOW_LO, SLOW_HI));
	endproperty
	a_slow_region: assert property (p_slow_region) else $error("three-state select disagrees with region");

	property p_mem_two_states;
		@(posedge ref_clk) disable iff (!rst_local_n)
			(bus_st == BS_T1 && !in_range(bus_addr, PERIPH_LO, PERIPH_HI)) |=> ##1 (bus_st != BS_T3);
	endproperty
	a_mem_two_states: assert property (p_mem_two_states) else $error("memory access took three states");

	property p_one_state;
		@(posedge ref_clk) disable iff (!rst_local_n) $onehot(cpu_state);
	endproperty
	a_one_state: assert property (p_one_state) else $error("core state not one-hot");

	property p_postinc_addr;
		@(posedge ref_clk) disable iff (!rst_local_n) (start_bus && req_mode == MODE_POSTINC) |=> (bus_addr == $past(ptr_lo));
	endproperty
	a_postinc_addr: assert property (p_postinc_addr) else $error("post-increment did not use old pointer");

	property p_predec_addr;
		@(posedge ref_clk) disable iff (!rst_local_n)
			(start_bus && req_mode == MODE_PREDEC && req_size == SIZE_BYTE) |=> (bus_addr == $past(ptr_lo) - 16'h0001);
	endproperty
	a_predec_addr: assert property (p_predec_addr) else $error("pre-decrement address wrong");

	property p_short_abs;
		@(posedge ref_clk) disable iff (!rst_local_n)
			(take && req_mode == MODE_ABS && req_ext_len == EXT_8) |=> (ea[15:8] == 8'hff);
	endproperty
	a_short_abs: assert property (p_short_abs) else $error("short absolute not in top page");

	property p_vector_page;
		@(posedge ref_clk) disable iff (!rst_local_n) (start_bus && req_mode == MODE_MEMIND) |=> (bus_addr[15:8] == 8'h00);
	endproperty
	a_vector_page: assert property (p_vector_page) else $error("vector read outside bottom page");

	property p_word_only;
		@(posedge ref_clk) disable iff (!rst_local_n)
			(bus_cyc && in_range(bus_addr, PERIPH_LO, PERIPH_HI) && !in_range(bus_addr, PERIPH8_LO, PERIPH8_HI)) |-> !bus_byte;
	endproperty
	a_word_only: assert property (p_word_only) else $error("byte cycle to word-only register");

	property p_illegal_mode;
		@(posedge ref_clk) disable iff (!rst_local_n) (take && !legal) |=> (mode_error && !done && !bus_cyc);
	endproperty
	a_illegal_mode: assert property (p_illegal_mode) else $error("illegal mode not refused");

endmodule // cpu_address_generation_unit

/* bench/bus_target_model.sv */
`timescale 1ns/10ps
// Far side of the bus: on-chip memory and peripheral registers, answering in every state
module bus_target_model (
	input wire logic ref_clk,
	input wire logic bus_cyc,
	input wire logic [15:0] bus_addr,
	input wire logic bus_write,
	input wire logic [15:0] bus_wr_data,
	output logic [15:0] bus_rd_data,
	output logic [15:0] last_wr_addr,
	output logic [15:0] last_wr_data
);
	// Last value driven, so an idle bus never repeats a stale match
	logic [15:0] shown = 16'h0000;
	// Data is a pattern of the address on a 16-bit path; byte pieces use the low lane
	always_comb begin
		bus_rd_data = bus_cyc ? {~bus_addr[7:0], bus_addr[7:0]} : ~shown;
	end
	// Remember what was shown and what was written
	always @(posedge ref_clk) begin
		if (bus_cyc) begin
			shown <= bus_rd_data;
		end
		if (bus_cyc && bus_write) begin
			last_wr_addr <= bus_addr;
			last_wr_data <= bus_wr_data;
		end
	end
endmodule // bus_target_model

/* bench/cpu_address_generation_unit_bench.sv */
`timescale 1ns/10ps
// Self-checking bench: a table of ordinary requests, then pointer, branch and core-state cases
module cpu_address_generation_unit_bench import agu_pkg::*; ;
	// One request and what it should give; kind 0 ea+op, 1 op, 2 mode error, 3 access error, 4 ea, 5 done
	typedef struct packed {
		addr_mode_t mode; instr_class_t cls; acc_size_t size; ext_len_t elen;
		logic [3:0] rg; logic [31:0] ext; logic [2:0] kind; logic [15:0] ea; logic [31:0] op; logic [3:0] lat;
	} row_t;
	logic ref_clk = 1'b0;
	logic rst_n, req_valid, req_write, reg_wr_en, halt_req, wake_req, exc_req, exc_done;
	addr_mode_t req_mode;
	instr_class_t req_class;
	acc_size_t req_size;
	ext_len_t req_ext_len;
	halt_kind_t halt_kind, halt_mode;
	cpu_state_t cpu_state;
	logic [3:0] req_reg;
	logic [31:0] req_ext, req_wdata, reg_wr_data, operand;
	logic [23:0] req_pc, jump_target;
	logic [15:0] req_opcode, bus_rd_data, ea, bus_addr, bus_wr_data, last_wr_addr, last_wr_data;
	logic [2:0] reg_wr_idx, bit_number;
	logic [1:0] trap_vector;
	logic busy, done, mode_error, access_error, bus_cyc, bus_write, bus_byte, bus_three_state, active_mode;
	int n_mismatch = 0;
	int n_tests = 0;
	// Register 1 holds 32'h00123450 throughout the table
	row_t rows [19] = '{
		'{MODE_DIRECT, CLASS_ALU, SIZE_LONG, EXT_8, 4'h1, 32'h0, 3'h1, 16'h0, 32'h00123450, 4'h1},
		'{MODE_DIRECT, CLASS_ALU, SIZE_BYTE, EXT_8, 4'h9, 32'h0, 3'h1, 16'h0, 32'h50, 4'h1},
		'{MODE_DIRECT, CLASS_ALU, SIZE_BYTE, EXT_8, 4'h1, 32'h0, 3'h1, 16'h0, 32'h34, 4'h1},
		'{MODE_DIRECT, CLASS_ALU, SIZE_WORD, EXT_8, 4'h9, 32'h0, 3'h1, 16'h0, 32'h0012, 4'h1},
		'{MODE_IMM, CLASS_ALU, SIZE_BYTE, EXT_8, 4'h0, 32'ha5, 3'h1, 16'h0, 32'ha5, 4'h1},
		'{MODE_IMM, CLASS_ALU, SIZE_LONG, EXT_32, 4'h0, 32'hdeadbeef, 3'h1, 16'h0, 32'hdeadbeef, 4'h1},
		'{MODE_INDIRECT, CLASS_XFER, SIZE_WORD, EXT_8, 4'h1, 32'h0, 3'h0, 16'h3450, 32'haf50, 4'h3},
		'{MODE_DISP, CLASS_XFER, SIZE_WORD, EXT_16, 4'h1, 32'hfff0, 3'h0, 16'h3440, 32'hbf40, 4'h3},
		'{MODE_DISP, CLASS_XFER, SIZE_WORD, EXT_24, 4'h1, 32'h00010010, 3'h0, 16'h3460, 32'h9f60, 4'h3},
		'{MODE_ABS, CLASS_XFER, SIZE_WORD, EXT_8, 4'h0, 32'h20, 3'h0, 16'hff20, 32'hdf20, 4'h3},
		'{MODE_ABS, CLASS_XFER, SIZE_WORD, EXT_16, 4'h0, 32'h8000, 3'h0, 16'h8000, 32'hff00, 4'h3},
		'{MODE_ABS, CLASS_XFER, SIZE_WORD, EXT_24, 4'h0, 32'h0012abcd, 3'h0, 16'habcd, 32'h32cd, 4'h3},
		'{MODE_ABS, CLASS_XFER, SIZE_LONG, EXT_16, 4'h0, 32'h1000, 3'h0, 16'h1000, 32'hff00fd02, 4'h5},
		'{MODE_ABS, CLASS_XFER, SIZE_WORD, EXT_16, 4'h0, 32'hf100, 3'h0, 16'hf100, 32'h0001, 4'h7},
		'{MODE_ABS, CLASS_XFER, SIZE_WORD, EXT_16, 4'h0, 32'hf400, 3'h0, 16'hf400, 32'hff00, 4'h3},
		'{MODE_ABS, CLASS_XFER, SIZE_BYTE, EXT_16, 4'h0, 32'hf400, 3'h3, 16'hf400, 32'h0, 4'h1},
		'{MODE_INDIRECT, CLASS_ALU, SIZE_WORD, EXT_8, 4'h1, 32'h0, 3'h2, 16'h0, 32'h0, 4'h1},
		'{MODE_DISP, CLASS_BIT, SIZE_BYTE, EXT_16, 4'h1, 32'h0, 3'h2, 16'h0, 32'h0, 4'h1},
		'{MODE_ABS, CLASS_BIT, SIZE_BYTE, EXT_8, 4'h0, 32'h30, 3'h0, 16'hff30, 32'h30, 4'h3}
	};

	cpu_address_generation_unit cpu_address_generation_unit_inst (.ref_clk(ref_clk), .rst_n(rst_n),
		.req_valid(req_valid), .req_mode(req_mode), .req_class(req_class), .req_size(req_size),
		.req_ext_len(req_ext_len), .req_reg(req_reg), .req_ext(req_ext), .req_pc(req_pc), .req_opcode(req_opcode),
		.req_write(req_write), .req_wdata(req_wdata), .reg_wr_en(reg_wr_en), .reg_wr_idx(reg_wr_idx),
		.reg_wr_data(reg_wr_data), .bus_rd_data(bus_rd_data), .halt_req(halt_req), .halt_kind(halt_kind),
		.wake_req(wake_req), .exc_req(exc_req), .exc_done(exc_done), .busy(busy), .done(done),
		.mode_error(mode_error), .access_error(access_error), .operand(operand), .ea(ea),
		.jump_target(jump_target), .bit_number(bit_number), .trap_vector(trap_vector), .bus_cyc(bus_cyc),
		.bus_addr(bus_addr), .bus_write(bus_write), .bus_byte(bus_byte), .bus_three_state(bus_three_state),
		.bus_wr_data(bus_wr_data), .cpu_state(cpu_state), .active_mode(active_mode), .halt_mode(halt_mode));
	bus_target_model bus_target_model_inst (.ref_clk(ref_clk), .bus_cyc(bus_cyc), .bus_addr(bus_addr),
		.bus_write(bus_write), .bus_wr_data(bus_wr_data), .bus_rd_data(bus_rd_data),
		.last_wr_addr(last_wr_addr), .last_wr_data(last_wr_data));

	// 50 MHz clock
	always #10 ref_clk = ~ref_clk;

	// Compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: %s seen %h expected %h", $time, m, seen, exp);
		end
	endtask
	// Counts, verdict, end of run
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// Load one long register through the side port
	task automatic wr_reg(input logic [2:0] i, input logic [31:0] d);
		@(negedge ref_clk);
		reg_wr_idx = i;
		reg_wr_data = d;
		reg_wr_en = 1'b1;
		@(negedge ref_clk);
		reg_wr_en = 1'b0;
	endtask
	// Hold the request over one edge, then count states until an answer pulses
	task automatic run(input row_t t);
		int n;
		logic [31:0] m;
		m = (t.size == SIZE_BYTE) ? 32'hff : (t.size == SIZE_WORD) ? 32'hffff : 32'hffffffff;
		@(negedge ref_clk);
		req_mode = t.mode;
		req_class = t.cls;
		req_size = t.size;
		req_ext_len = t.elen;
		req_reg = t.rg;
		req_ext = t.ext;
		req_valid = 1'b1;
		@(negedge ref_clk);
		req_valid = 1'b0;
		n = 1;
		if (t.kind == 3'h0 || t.kind == 3'h4) chk({31'h0, busy}, 32'h1, "busy in bus cycle");
		while (done !== 1'b1 && mode_error !== 1'b1 && access_error !== 1'b1 && n < 20) begin
			@(negedge ref_clk);
			n++;
		end
		chk(32'(n), 32'(t.lat), "states to answer");
		chk({29'h0, done, mode_error, access_error},
			{29'h0, t.kind != 3'h2 && t.kind != 3'h3, t.kind == 3'h2, t.kind == 3'h3}, "answer kind");
		if (t.kind == 3'h0 || t.kind == 3'h4) chk({16'h0, ea}, {16'h0, t.ea}, "address");
		if (t.kind < 3'h2) chk(operand & m, t.op, "operand");
		@(negedge ref_clk);
		chk({31'h0, done}, 32'h0, "answer lasts one state");
	endtask

	// Watchdog well beyond the expected 150 cycles
	initial begin
		#200000;
		n_mismatch++;
		final_report();
	end

	// Main sequence
	initial begin
		{rst_n, req_valid, req_write, reg_wr_en, halt_req, wake_req, exc_req, exc_done} = 8'h00;
		{req_reg, req_ext, req_wdata, reg_wr_data, req_pc, reg_wr_idx} = '0;
		req_mode = MODE_DIRECT;
		req_class = CLASS_ALU;
		req_size = SIZE_BYTE;
		req_ext_len = EXT_8;
		halt_kind = HALT_SLEEP;
		req_opcode = 16'h0050;
		repeat (8) @(negedge ref_clk);
		chk({28'h0, cpu_state}, {28'h0, CPU_RESET}, "state in reset");
		repeat (8) @(negedge ref_clk);
		rst_n = 1'b1;
		repeat (4) @(negedge ref_clk);
		chk({28'h0, cpu_state}, {28'h0, CPU_EXCEPT}, "reset handling");
		exc_done = 1'b1;
		@(negedge ref_clk);
		exc_done = 1'b0;
		chk({27'h0, active_mode, cpu_state}, {27'h0, 1'b1, CPU_EXEC}, "execution");
		wr_reg(3'h1, 32'h00123450);
		foreach (rows[i]) run(rows[i]);
		chk({27'h0, bit_number, trap_vector}, {27'h0, 3'h5, 2'h1}, "opcode constants");
		// Pointer update is seen by the next request
		wr_reg(3'h3, 32'h00002000);
		run('{MODE_POSTINC, CLASS_XFER, SIZE_WORD, EXT_8, 4'h3, 32'h0, 3'h0, 16'h2000, 32'hff00, 4'h3});
		run('{MODE_DIRECT, CLASS_ALU, SIZE_LONG, EXT_8, 4'h3, 32'h0, 3'h1, 16'h0, 32'h2002, 4'h1});
		run('{MODE_PREDEC, CLASS_XFER, SIZE_LONG, EXT_8, 4'h3, 32'h0, 3'h0, 16'h1ffe, 32'h01feff00, 4'h5});
		run('{MODE_DIRECT, CLASS_ALU, SIZE_LONG, EXT_8, 4'h3, 32'h0, 3'h1, 16'h0, 32'h1ffe, 4'h1});
		// Byte write lands on the low lane
		req_write = 1'b1;
		req_wdata = 32'h000000a5;
		run('{MODE_ABS, CLASS_XFER, SIZE_BYTE, EXT_16, 4'h0, 32'h2345, 3'h4, 16'h2345, 32'h0, 4'h3});
		req_write = 1'b0;
		chk({last_wr_addr, 8'h0, last_wr_data[7:0]}, {16'h2345, 8'h0, 8'ha5}, "written byte");
		// Relative branch backwards and vector-indirect jump
		req_pc = 24'h010000;
		run('{MODE_PCREL, CLASS_BRANCH, SIZE_WORD, EXT_16, 4'h0, 32'h8002, 3'h5, 16'h0, 32'h0, 4'h1});
		chk({8'h0, jump_target}, 32'h008002, "branch target");
		run('{MODE_MEMIND, CLASS_BRANCH, SIZE_LONG, EXT_8, 4'h0, 32'h10, 3'h4, 16'h0010, 32'h0, 4'h5});
		chk({8'h0, jump_target}, 32'h0010ed12, "vector target");
		run('{MODE_PCREL, CLASS_XFER, SIZE_WORD, EXT_8, 4'h0, 32'h0, 3'h2, 16'h0, 32'h0, 4'h1});
		// Halt refuses requests until woken; exception round trip
		halt_kind = HALT_STANDBY;
		halt_req = 1'b1;
		@(negedge ref_clk);
		halt_req = 1'b0;
		chk({25'h0, active_mode, halt_mode, cpu_state}, {25'h0, 1'b0, HALT_STANDBY, CPU_HALT}, "halt");
		req_mode = MODE_DIRECT;
		req_valid = 1'b1;
		repeat (2) begin
			@(negedge ref_clk);
			chk({31'h0, done}, 32'h0, "refused in halt");
		end
		req_valid = 1'b0;
		wake_req = 1'b1;
		@(negedge ref_clk);
		wake_req = 1'b0;
		chk({28'h0, cpu_state}, {28'h0, CPU_EXEC}, "wake");
		exc_req = 1'b1;
		@(negedge ref_clk);
		exc_req = 1'b0;
		chk({27'h0, active_mode, cpu_state}, {27'h0, 1'b0, CPU_EXCEPT}, "exception");
		exc_done = 1'b1;
		@(negedge ref_clk);
		exc_done = 1'b0;
		chk({28'h0, cpu_state}, {28'h0, CPU_EXEC}, "return");
		final_report();
	end
endmodule // cpu_address_generation_unit_bench
